// *** hw/adccal_top.sv ***
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
// Contract
// RQ1: dual mode routes A to channel A, B to B; swap bit exchanges them.
// RQ2: swap bit is ignored in single-channel mode.
// RQ3: single input field: code 1 picks input A, code 2 input B.
// RQ4: single input field is ignored outside single-channel mode.
// RQ5: calibration enable high runs calibration, low holds it in reset.
// RQ6: calibration enable low also resets the digital and link clock dividers.
// RQ7: setting enable again re-runs calibration with the new settings.
// RQ8: software enables calibration before link, disables link before calibration.
// RQ9: software writes calibration config only while calibration is disabled.
// RQ10: offset filter bit enables offset filtering.
// RQ11: background offset bit works only with background calibration enabled.
// RQ12: foreground offset bit works only with foreground calibration enabled.
// RQ13: background bit enables continuous background calibration.
// RQ14: start clears calibration values, then foreground runs if its bit set.
// RQ15: stopped bit reads 1 when background parks, 0 when running again.
// RQ16: without background, stopped sets when foreground completes or is skipped.
// RQ17: foreground complete bit rises when foreground calibration finishes.
// RQ18: status pin select: 0 foreground done, 2 alarm, 3 low, 1 reserved.
// RQ19: trigger source bit picks software bit (0) or hardware input (1).
// RQ20: without a trigger need, keep software source with software bit at 1.
// RQ21: status register ignores writes, reserved bits read zero.
// RQ22: software avoids the reserved field codes.
module adccal_top (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire adccal_pkg::adccal_wbreq_type  wbReq,
    output logic [31:0]                        wbDatOut,
    output logic                               wbAck,
    input  wire logic                          hardwareTriggerInput,
    input  wire logic                          alarmIn,
    output logic                               channelASelB,
    output logic                               channelBSelB,
    output logic                               calibrationStatusPin,
    output logic                               calValuesClear,
    output logic                               fgCalActive,
    output logic                               bgCalActive,
    output logic                               fgOffsetActive,
    output logic                               bgOffsetActive,
    output logic                               offsetFilterActive,
    output logic                               dividerReset,
    output logic                               digitalClkTick,
    output logic                               linkClkTick,
    output logic                               serialLinkEnable
);

    // ==========================================================
    // register state
    // ==========================================================
    logic [7:0]  route_q;
    logic [7:0]  calEn_q;
    logic [7:0]  calCfg_q;
    logic [7:0]  pinCfg_q;
    logic [7:0]  swTrig_q;
    logic [7:0]  linkEn_q;
    logic [7:0]  mode_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [1:0]  divCount_q;
    logic        digTick_q;
    logic        linkTick_q;
    logic        chA_q;
    logic        chB_q;
    logic        statPin_q;
    logic [9:0]  regIdx;
    logic        access;
    logic        wrCommit;
    logic        wrByte0;
    logic [7:0]  wrData;
    logic        calEnable;
    logic        singleMode;
    logic        trigger;
    logic        fgDone;
    logic        stopped;
    adccal_pkg::adccal_calcfg_type cfg;

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic isMapped(input logic [9:0] idx);
        isMapped = idx == adccal_pkg::IDX_ROUTE   || idx == adccal_pkg::IDX_CALEN
                || idx == adccal_pkg::IDX_CALCFG  || idx == adccal_pkg::IDX_CALIBRATION_STATUS_PIN
                || idx == adccal_pkg::IDX_PINCFG  || idx == adccal_pkg::IDX_SWTRIG
                || idx == adccal_pkg::IDX_LINKEN  || idx == adccal_pkg::IDX_MODE;
    endfunction

    function automatic logic hits(input logic [9:0] idx, input logic [9:0] want);
        hits = (idx == want);
    endfunction

    // ==========================================================
    // wishbone classic slave
    // ==========================================================
    assign regIdx   = wbReq.adr[11:2];
    assign access   = wbReq.cyc && wbReq.stb;
    // write lands on the edge where the master sees ack
    assign wrCommit = access && wbReq.we && ack_q;
    assign wrByte0  = wrCommit && wbReq.sel[0] && isMapped(regIdx);
    assign wrData   = wbReq.dat[7:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access && !ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdat_q <= 32'h0000_0000;
        end else if (access && !ack_q) begin
            case (regIdx)
                adccal_pkg::IDX_ROUTE:   rdat_q <= {24'h000000, route_q};
                adccal_pkg::IDX_CALEN:   rdat_q <= {24'h000000, calEn_q};
                adccal_pkg::IDX_CALCFG:  rdat_q <= {24'h000000, calCfg_q};
                adccal_pkg::IDX_CALIBRATION_STATUS_PIN: rdat_q <= {30'h0000_0000, stopped, fgDone}; // [RQ21]
                adccal_pkg::IDX_PINCFG:  rdat_q <= {24'h000000, pinCfg_q};
                adccal_pkg::IDX_SWTRIG:  rdat_q <= {24'h000000, swTrig_q};
                adccal_pkg::IDX_LINKEN:  rdat_q <= {24'h000000, linkEn_q};
                adccal_pkg::IDX_MODE:    rdat_q <= {24'h000000, mode_q};
                default:                 rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wbAck    = ack_q && access;
    assign wbDatOut = rdat_q;

    // ==========================================================
    // writable registers (status register has no write path)
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route_q <= adccal_pkg::RST_ROUTE;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_ROUTE)) begin
            route_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calEn_q <= adccal_pkg::RST_CALEN;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_CALEN)) begin
            calEn_q <= wrData;
        end
    end

    // not guarded against writes while enabled; software keeps that order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            calCfg_q <= adccal_pkg::RST_CALCFG;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_CALCFG)) begin
            calCfg_q <= wrData; // [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinCfg_q <= adccal_pkg::RST_PINCFG;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_PINCFG)) begin
            pinCfg_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            swTrig_q <= adccal_pkg::RST_SWTRIG; // [RQ20]
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_SWTRIG)) begin
            swTrig_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkEn_q <= adccal_pkg::RST_LINKEN;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_LINKEN)) begin
            linkEn_q <= wrData; // [RQ8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= adccal_pkg::RST_MODE;
        end else if (wrByte0 && hits(regIdx, adccal_pkg::IDX_MODE)) begin
            mode_q <= wrData;
        end
    end

    // ==========================================================
    // decoded controls
    // ==========================================================
    assign calEnable  = calEn_q[adccal_pkg::POS_CAL_EN];
    assign singleMode = mode_q[adccal_pkg::POS_SINGLE_MD];
    assign cfg.osFilter = calCfg_q[adccal_pkg::POS_OSFILT];
    assign cfg.bgOffset = calCfg_q[adccal_pkg::POS_BG_OFS];
    assign cfg.fgOffset = calCfg_q[adccal_pkg::POS_FG_OFS];
    assign cfg.bgEnable = calCfg_q[adccal_pkg::POS_BG_EN];
    assign cfg.fgEnable = calCfg_q[adccal_pkg::POS_FG_EN];

    // one source only, the other is ignored
    assign trigger = pinCfg_q[adccal_pkg::POS_TRIG_SRC] ? hardwareTriggerInput
                   : swTrig_q[adccal_pkg::POS_SW_TRIG]; // [RQ19]

    // ==========================================================
    // input routing (1 = channel samples input B)
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chA_q <= 1'b0;
            chB_q <= 1'b1;
        end else if (singleMode) begin
            // reserved codes fall back to input A
            chA_q <= (route_q[adccal_pkg::POS_SINGLE_LO +: 2] == adccal_pkg::SINGLE_IN_B); // [RQ3]
            chB_q <= (route_q[adccal_pkg::POS_SINGLE_LO +: 2] == adccal_pkg::SINGLE_IN_B); // [RQ2]
        end else begin
            chA_q <= route_q[adccal_pkg::POS_DUAL_SWAP]; // [RQ1] [RQ4]
            chB_q <= !route_q[adccal_pkg::POS_DUAL_SWAP];
        end
    end

    assign channelASelB = chA_q;
    assign channelBSelB = chB_q;

    // ==========================================================
    // clock dividers for digital block and serial link
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n || !calEnable) begin
            divCount_q <= 2'h0; // [RQ6]
            digTick_q  <= 1'b0;
            linkTick_q <= 1'b0;
        end else begin
            divCount_q <= divCount_q + 2'h1;
            digTick_q  <= divCount_q[0];
            linkTick_q <= (divCount_q == adccal_pkg::DIV_LAST);
        end
    end

    assign dividerReset     = !calEnable; // [RQ6]
    assign digitalClkTick   = digTick_q;
    assign linkClkTick      = linkTick_q;
    assign serialLinkEnable = linkEn_q[adccal_pkg::POS_LINK_EN];

    // ==========================================================
    // calibration sequencer
    // ==========================================================
    adccal_engine u_adccal_engine (
        .clk            (clk),
        .rst_n          (rst_n),
        .calEnable      (calEnable), // [RQ5] [RQ7]
        .trigger        (trigger),
        .cfg            (cfg),
        .calValuesClear (calValuesClear),
        .fgActive       (fgCalActive),
        .bgActive       (bgCalActive),
        .fgDone         (fgDone),
        .stopped        (stopped)
    );

    assign fgOffsetActive     = fgCalActive && cfg.fgOffset; // [RQ12]
    assign bgOffsetActive     = bgCalActive && cfg.bgOffset; // [RQ11]
    assign offsetFilterActive = calEnable && cfg.osFilter;   // [RQ10]

    // ==========================================================
    // status pin
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            statPin_q <= 1'b0;
        end else begin
            case (pinCfg_q[adccal_pkg::POS_STAT_SELLO +: 2])
                adccal_pkg::STATSEL_FG:    statPin_q <= fgDone;  // [RQ18]
                adccal_pkg::STATSEL_ALARM: statPin_q <= alarmIn; // [RQ18]
                adccal_pkg::STATSEL_LOW:   statPin_q <= 1'b0;
                default:                   statPin_q <= 1'b0; // [RQ22]
            endcase
        end
    end

    assign calibrationStatusPin = statPin_q;

endmodule

// *** include/adccal_pkg.sv ***
package adccal_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [9:0] IDX_ROUTE   = 10'h060;
    localparam logic [9:0] IDX_CALEN   = 10'h061;
    localparam logic [9:0] IDX_CALCFG  = 10'h062;
    localparam logic [9:0] IDX_CALIBRATION_STATUS_PIN = 10'h06a;
    localparam logic [9:0] IDX_PINCFG  = 10'h06b;
    localparam logic [9:0] IDX_SWTRIG  = 10'h06c;
    localparam logic [9:0] IDX_LINKEN  = 10'h0a0;
    localparam logic [9:0] IDX_MODE    = 10'h0a1;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] RST_ROUTE  = 8'h01;
    localparam logic [7:0] RST_CALEN  = 8'h01;
    localparam logic [7:0] RST_CALCFG = 8'h01;
    localparam logic [7:0] RST_PINCFG = 8'h00;
    localparam logic [7:0] RST_SWTRIG = 8'h01;
    localparam logic [7:0] RST_LINKEN = 8'h00;
    localparam logic [7:0] RST_MODE   = 8'h00;

    // ==========================================================
    // field positions
    // ==========================================================
    localparam int POS_DUAL_SWAP  = 4;
    localparam int POS_SINGLE_LO  = 0;
    localparam int POS_CAL_EN     = 0;
    localparam int POS_OSFILT     = 4;
    localparam int POS_BG_OFS     = 3;
    localparam int POS_FG_OFS     = 2;
    localparam int POS_BG_EN      = 1;
    localparam int POS_FG_EN      = 0;
    localparam int POS_STOPPED    = 1;
    localparam int POS_FOREGROUND_COMPLETE_BIT    = 0;
    localparam int POS_STAT_SELLO = 1;
    localparam int POS_TRIG_SRC   = 0;
    localparam int POS_SW_TRIG    = 0;
    localparam int POS_LINK_EN    = 0;
    localparam int POS_SINGLE_MD  = 0;

    // ==========================================================
    // codes
    // ==========================================================
    localparam logic [1:0] SINGLE_IN_A   = 2'h1;
    localparam logic [1:0] SINGLE_IN_B   = 2'h2;
    localparam logic [1:0] STATSEL_FG    = 2'h0;
    localparam logic [1:0] STATSEL_ALARM = 2'h2;
    localparam logic [1:0] STATSEL_LOW   = 2'h3;

    // ==========================================================
    // timing: 10 MHz clock
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam int FG_CAL_TIME_NS = 1600;
    localparam logic [7:0] FG_CAL_CYCLES = 8'((FG_CAL_TIME_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS);
    localparam logic [1:0] DIV_LAST = 2'h3;

    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } adccal_wbreq_type;

    typedef struct packed {
        logic osFilter;
        logic bgOffset;
        logic fgOffset;
        logic bgEnable;
        logic fgEnable;
    } adccal_calcfg_type;

    typedef enum logic [5:0] {
        ST_HOLD  = 6'b000001,
        ST_CLEAR = 6'b000010,
        ST_FG    = 6'b000100,
        ST_BG    = 6'b001000,
        ST_STOP  = 6'b010000,
        ST_DONE  = 6'b100000
    } adccal_state_type;

endpackage

// *** hw/adccal_engine.sv ***
`timescale 1ns/10ps
module adccal_engine (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         calEnable,
    input  wire logic                         trigger,
    input  wire adccal_pkg::adccal_calcfg_type cfg,
    output logic                              calValuesClear,
    output logic                              fgActive,
    output logic                              bgActive,
    output logic                              fgDone,
    output logic                              stopped
);
    adccal_pkg::adccal_state_type state_q;
    logic [7:0]                   count_q;
    logic                         fgDone_q;
    logic                         stopped_q;

    // ==========================================================
    // sequencer
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n || !calEnable) begin
            state_q <= adccal_pkg::ST_HOLD; // [RQ5]
        end else begin
            case (state_q)
                adccal_pkg::ST_HOLD: begin
                    state_q <= adccal_pkg::ST_CLEAR; // [RQ7]
                end
                adccal_pkg::ST_CLEAR: begin
                    if (cfg.fgEnable) begin
                        state_q <= adccal_pkg::ST_FG; // [RQ14]
                    end else if (cfg.bgEnable) begin
                        state_q <= adccal_pkg::ST_BG;
                    end else begin
                        state_q <= adccal_pkg::ST_DONE;
                    end
                end
                adccal_pkg::ST_FG: begin
                    if (count_q == adccal_pkg::FG_CAL_CYCLES) begin
                        state_q <= cfg.bgEnable ? adccal_pkg::ST_BG : adccal_pkg::ST_DONE;
                    end
                end
                adccal_pkg::ST_BG: begin
                    // low trigger parks background calibration at its phase
                    if (!trigger) begin
                        state_q <= adccal_pkg::ST_STOP;
                    end
                end
                adccal_pkg::ST_STOP: begin
                    if (trigger) begin
                        state_q <= adccal_pkg::ST_BG;
                    end
                end
                adccal_pkg::ST_DONE: begin
                    state_q <= adccal_pkg::ST_DONE;
                end
                default: begin
                    state_q <= adccal_pkg::ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || state_q != adccal_pkg::ST_FG) begin
            count_q <= 8'h00;
        end else begin
            count_q <= count_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !calEnable || state_q == adccal_pkg::ST_HOLD) begin
            fgDone_q <= 1'b0;
        end else if (state_q == adccal_pkg::ST_FG && count_q == adccal_pkg::FG_CAL_CYCLES) begin
            fgDone_q <= 1'b1; // [RQ17]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !calEnable) begin
            stopped_q <= 1'b0;
        end else begin
            // stop phase, or foreground done/skipped with background off
            stopped_q <= (state_q == adccal_pkg::ST_STOP && !trigger)
                      || state_q == adccal_pkg::ST_DONE; // [RQ15] [RQ16]
        end
    end

    assign calValuesClear = (state_q == adccal_pkg::ST_CLEAR); // [RQ14]
    assign fgActive       = (state_q == adccal_pkg::ST_FG);
    assign bgActive       = (state_q == adccal_pkg::ST_BG); // [RQ13]
    assign fgDone         = fgDone_q;
    assign stopped        = stopped_q;
endmodule

// *** test/adccal_asserts.sv ***
`timescale 1ns/10ps
module adccal_asserts (
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire adccal_pkg::adccal_wbreq_type wbReq,
    input wire logic                         wbAck,
    input wire logic                         calValuesClear,
    input wire logic                         fgCalActive,
    input wire logic                         bgCalActive,
    input wire logic                         fgOffsetActive,
    input wire logic                         bgOffsetActive,
    input wire logic                         dividerReset,
    input wire logic                         digitalClkTick,
    input wire logic                         linkClkTick
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // foreground run length
    // ==========================================
    logic [7:0] fgRun_q;
    always_ff @(posedge clk) begin
        if (!rst_n || !fgCalActive) fgRun_q <= 8'h00;
        else fgRun_q <= fgRun_q + 8'h01;
    end
    sequence reqStart;
        $rose(wbReq.cyc && wbReq.stb);
    endsequence
    sequence ackOnce;
        wbAck ##1 !wbAck;
    endsequence
    a_ack_latency: assert property (reqStart |=> ackOnce) else $error("ack timing wrong");
    a_fg_ofs_gate: assert property (fgOffsetActive |-> fgCalActive)
        else $error("fg offset without fg");
    a_bg_ofs_gate: assert property (bgOffsetActive |-> bgCalActive)
        else $error("bg offset without bg");
    a_clear_first: assert property ($rose(fgCalActive) |-> $past(calValuesClear))
        else $error("fg started without clear");
    a_fg_length: assert property (
        $fell(fgCalActive) && !dividerReset |-> fgRun_q == adccal_pkg::FG_CAL_CYCLES + 8'h01)
        else $error("fg length wrong");
    a_hold_reset: assert property (dividerReset[*2] |-> !fgCalActive && !bgCalActive)
        else $error("calibration runs while disabled");
    a_div_quiet: assert property (dividerReset[*3] |-> !digitalClkTick && !linkClkTick)
        else $error("dividers run while disabled");
    a_link_period: assert property (linkClkTick |=> !linkClkTick[*3])
        else $error("link tick too often");
    a_cal_restart: assert property ($fell(dividerReset) |-> ##[1:3] calValuesClear)
        else $error("no restart after enable");
endmodule

bind adccal_top adccal_asserts u_adccal_asserts (.clk, .rst_n, .wbReq, .wbAck, .calValuesClear,
    .fgCalActive, .bgCalActive, .fgOffsetActive, .bgOffsetActive, .dividerReset,
    .digitalClkTick, .linkClkTick);

// *** test/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
    logic                         clk = 1'b0;
    logic                         rst_n = 1'b0;
    adccal_pkg::adccal_wbreq_type wbReq = '0;
    logic                         hardwareTriggerInput = 1'b0;
    logic                         alarmIn = 1'b0;
    logic [31:0]                  wbDatOut;
    logic                         wbAck, channelASelB, channelBSelB, calibrationStatusPin;
    logic                         calValuesClear, fgCalActive, bgCalActive, fgOffsetActive;
    logic                         bgOffsetActive, offsetFilterActive, dividerReset;
    logic                         digitalClkTick, linkClkTick, serialLinkEnable;
    int                           failures = 0;
    int                           compares = 0;
    int                           i;
    logic [31:0]                  seed = 32'hd9f22c2a;
    logic [31:0]                  r;
    logic [7:0]                   rd, rte;

    always #50 clk = ~clk;

    adccal_top u_adccal_top (.clk, .rst_n, .wbReq, .wbDatOut, .wbAck, .hardwareTriggerInput,
        .alarmIn, .channelASelB, .channelBSelB, .calibrationStatusPin, .calValuesClear,
        .fgCalActive, .bgCalActive, .fgOffsetActive, .bgOffsetActive, .offsetFilterActive,
        .dividerReset, .digitalClkTick, .linkClkTick, .serialLinkEnable);

    // ==========================================
    // helpers
    // ==========================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // {channel A takes B, channel B takes B}
    function automatic logic [1:0] expRoute(input logic single, input logic [7:0] v);
        if (single) return {2{v[1:0] == adccal_pkg::SINGLE_IN_B}};
        return v[adccal_pkg::POS_DUAL_SWAP] ? 2'b10 : 2'b01;
    endfunction

    task automatic xfer(input logic [9:0] idx, input logic we, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hf, dat: {24'h0, d}};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = wbDatOut[7:0];
        wbReq <= '0;
    endtask

    task automatic rdStat();
        xfer(adccal_pkg::IDX_CALIBRATION_STATUS_PIN, 1'b0, 8'h00);
    endtask

    task automatic test_done();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog well beyond the roughly 300 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        xfer(adccal_pkg::IDX_CALEN, 1'b0, 8'h00);
        `CHK(rd, 8'h01)
        xfer(adccal_pkg::IDX_CALCFG, 1'b0, 8'h00);
        `CHK(rd, 8'h01)
        xfer(adccal_pkg::IDX_PINCFG, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        xfer(adccal_pkg::IDX_ROUTE, 1'b0, 8'h00);
        `CHK(rd, 8'h01)
        repeat (20) @(posedge clk);
        rdStat();
        `CHK(rd, 8'h03)
        `CHK(calibrationStatusPin, 1'b1)
        xfer(adccal_pkg::IDX_CALIBRATION_STATUS_PIN, 1'b1, 8'hfc);
        rdStat();
        `CHK(rd, 8'h03)
        xfer(10'h3ff, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        xfer(adccal_pkg::IDX_PINCFG, 1'b1, 8'h04);
        for (i = 0; i < 6; i++) begin
            r = rnd();
            @(posedge clk) alarmIn <= r[0];
            repeat (2) @(posedge clk);
            `CHK(calibrationStatusPin, alarmIn)
        end
        // alarm high so the forced-low code is really seen
        alarmIn <= 1'b1;
        xfer(adccal_pkg::IDX_PINCFG, 1'b1, 8'h06);
        repeat (2) @(posedge clk);
        `CHK(calibrationStatusPin, 1'b0)
        // reserved single-input codes are never written
        for (i = 0; i < 16; i++) begin
            r = rnd();
            rte = {r[7:2], r[1] ? 2'h2 : 2'h1};
            xfer(adccal_pkg::IDX_MODE, 1'b1, {7'h0, r[8]});
            xfer(adccal_pkg::IDX_ROUTE, 1'b1, rte);
            repeat (2) @(posedge clk);
            `CHK({channelASelB, channelBSelB}, expRoute(r[8], rte))
        end
        xfer(adccal_pkg::IDX_LINKEN, 1'b1, 8'h01);
        @(posedge clk);
        `CHK(serialLinkEnable, 1'b1)
        xfer(adccal_pkg::IDX_LINKEN, 1'b1, 8'h00);
        xfer(adccal_pkg::IDX_CALEN, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        `CHK(dividerReset, 1'b1)
        `CHK(fgCalActive | bgCalActive, 1'b0)
        r = rnd();
        xfer(adccal_pkg::IDX_CALCFG, 1'b1, {3'h0, r[4], 4'he});
        xfer(adccal_pkg::IDX_CALEN, 1'b1, 8'h01);
        repeat (6) @(posedge clk);
        `CHK(bgCalActive, 1'b1)
        `CHK(bgOffsetActive, 1'b1)
        `CHK(fgOffsetActive, 1'b0)
        `CHK(offsetFilterActive, r[4])
        rdStat();
        `CHK(rd, 8'h00)
        // hardware input high must not keep the software-sourced trigger up
        hardwareTriggerInput <= 1'b1;
        xfer(adccal_pkg::IDX_SWTRIG, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        rdStat();
        `CHK(rd, 8'h02)
        @(posedge clk) hardwareTriggerInput <= 1'b1;
        xfer(adccal_pkg::IDX_PINCFG, 1'b1, 8'h01);
        repeat (2) @(posedge clk);
        rdStat();
        `CHK(rd, 8'h00)
        @(posedge clk) hardwareTriggerInput <= 1'b0;
        repeat (2) @(posedge clk);
        rdStat();
        `CHK(rd, 8'h02)
        xfer(adccal_pkg::IDX_CALEN, 1'b1, 8'h00);
        xfer(adccal_pkg::IDX_CALCFG, 1'b1, 8'h15);
        xfer(adccal_pkg::IDX_CALEN, 1'b1, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(fgCalActive, 1'b1)
        `CHK(fgOffsetActive, 1'b1)
        `CHK(offsetFilterActive, 1'b1)
        repeat (20) @(posedge clk);
        rdStat();
        `CHK(rd, 8'h03)
        test_done();
    end
endmodule
